// ==== common/puec_pkg.sv ====
// Purpose: shared constants of the up/down event counter bank
// Assumes: APB slave with 32-bit data, one word per register
// Notes: level bits of a counter share one layout in register and state
package puec_pkg;
	localparam int NUM_CNT_DEF = 256;
	localparam int CNT_W_DEF = 32;
	localparam logic [31:0] CNT_MAX = 32'h7fffffff;

	localparam logic [7:0] REG_SEL = 8'h00;
	localparam logic [7:0] REG_LVL = 8'h04;
	localparam logic [7:0] REG_PRESET = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0c;
	localparam logic [7:0] REG_ZERO = 8'h10;
	localparam logic [7:0] REG_ACT = 8'h14;
	localparam logic [7:0] REG_ISTS = 8'h18;
	localparam logic [7:0] REG_IMASK = 8'h1c;

	localparam int LVL_UP = 0;
	localparam int LVL_DN = 1;
	localparam int LVL_EN = 2;
	localparam int LVL_PR = 3;
	localparam logic [3:0] LVL_RST = 4'h4;

	localparam int IRQ_ZERO = 0;
	localparam int IRQ_WRAP = 1;
	localparam logic [1:0] IMASK_RST = 2'h0;
endpackage

// ==== logic/puec_step.sv ====
// Purpose: next count of one counter for one evaluation
// Assumes: prev_lvl holds the levels seen at the previous evaluation
// Notes: purely combinational; count wraps as two's complement
`timescale 1ns/1ns
module puec_step #(
	parameter int CNT_W = puec_pkg::CNT_W_DEF
) (
	input wire logic [CNT_W-1:0] count,
	input wire logic [3:0] prev_lvl,
	input wire logic [3:0] new_lvl,
	input wire logic [CNT_W-1:0] preset,
	output logic [CNT_W-1:0] next_count,
	output logic wrapped
);
	import puec_pkg::*;

	logic up_e;
	logic dn_e;
	logic pr_e;
	logic [CNT_W-1:0] max_v;

	always_comb begin
		up_e = new_lvl[LVL_UP] & ~prev_lvl[LVL_UP];
		dn_e = new_lvl[LVL_DN] & ~prev_lvl[LVL_DN];
		pr_e = new_lvl[LVL_PR] & ~prev_lvl[LVL_PR];
		max_v = {1'b0, {(CNT_W-1){1'b1}}};
		next_count = count;
		wrapped = 1'b0;
		if (pr_e) begin
			next_count = preset;
		end else if (new_lvl[LVL_EN] && (up_e ^ dn_e)) begin
			// a low enable drops the edge rather than deferring it
			if (up_e) begin
				next_count = count + CNT_W'(1);
				wrapped = (count == max_v);
			end else begin
				next_count = count - CNT_W'(1);
				wrapped = (count == ~max_v);
			end
		end
	end
endmodule

// ==== logic/puec_counter_bank.sv ====
// Purpose: bank of up/down event counters reached over APB
// Assumes: one APB write to the level register is one evaluation cycle
// Notes: only the selected counter is evaluated, so one adder serves all
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
module puec_counter_bank #(
	parameter int NUM_CNT = puec_pkg::NUM_CNT_DEF,
	parameter int CNT_W = puec_pkg::CNT_W_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic [NUM_CNT-1:0] zero_flags,
	output logic [CNT_W-1:0] sel_count
);
	import puec_pkg::*;

	localparam int IDX_W = (NUM_CNT > 1) ? $clog2(NUM_CNT) : 1;
	// top positive count at the configured width, not the 32-bit one
	localparam logic [CNT_W-1:0] TOP_V = {1'b0, {(CNT_W-1){1'b1}}};

	generate
		if (NUM_CNT < 2 || NUM_CNT > 256) begin : g_num_chk
			$error("counter count must lie in 2..256");
		end
		if (CNT_W < 2 || CNT_W > 32) begin : g_w_chk
			$error("count width must lie in 2..32");
		end
	endgenerate

	typedef struct packed {
		logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
		logic [NUM_CNT-1:0][3:0] lvl;
		logic [NUM_CNT-1:0] zero;
		logic [IDX_W-1:0] sel;
		logic [CNT_W-1:0] preset;
		logic [1:0] ists;
		logic [1:0] imask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [CNT_W-1:0] sel_count;
	} puec_state_t;

	puec_state_t s_r;
	puec_state_t s_nxt;

	logic [CNT_W-1:0] cur_cnt;
	logic [3:0] cur_lvl;
	logic [CNT_W-1:0] step_cnt;
	logic step_wrap;
	logic acc_wr;
	logic setup;

	function automatic logic puec_mapped(input logic [7:0] a);
		case (a)
			REG_SEL, REG_LVL, REG_PRESET, REG_COUNT,
			REG_ZERO, REG_ACT, REG_ISTS, REG_IMASK: puec_mapped = 1'b1;
			default: puec_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] puec_pad(input logic [CNT_W-1:0] v);
		logic [31:0] w;
		w = '0;
		w[CNT_W-1:0] = v;
		puec_pad = w;
	endfunction

	assign cur_cnt = s_r.cnt[s_r.sel];
	assign cur_lvl = s_r.lvl[s_r.sel];
	assign setup = psel & ~penable;
	// pready comes from a flop, so every access phase lasts one cycle
	assign acc_wr = psel & penable & s_r.pready & pwrite & ~s_r.pslverr;

	puec_step #(
		.CNT_W(CNT_W)
	) u_step (
		.count(cur_cnt),
		.prev_lvl(cur_lvl),
		.new_lvl(pwdata[3:0]),
		.preset(s_r.preset),
		.next_count(step_cnt),
		.wrapped(step_wrap)
	);

	always_comb begin
		logic [1:0] ev;
		logic [1:0] clr;
		ev = 2'h0;
		clr = 2'h0;
		s_nxt = s_r;
		s_nxt.pready = setup;
		s_nxt.pslverr = 1'b0;
		if (setup) begin
			s_nxt.pslverr = ~puec_mapped(paddr);
			s_nxt.prdata = 32'h0;
			if (!pwrite) begin
				// reads only look, nothing here alters a count
				case (paddr)
					REG_SEL: s_nxt.prdata[IDX_W-1:0] = s_r.sel;
					REG_LVL: s_nxt.prdata[3:0] = cur_lvl;
					REG_PRESET: s_nxt.prdata = puec_pad(s_r.preset);
					REG_COUNT: s_nxt.prdata = puec_pad(cur_cnt);
					REG_ZERO: s_nxt.prdata[0] = s_r.zero[s_r.sel];
					REG_ISTS: s_nxt.prdata[1:0] = s_r.ists;
					REG_IMASK: s_nxt.prdata[1:0] = s_r.imask;
					default: s_nxt.prdata = 32'h0;
				endcase
			end
		end
		if (acc_wr) begin
			case (paddr)
				REG_SEL: begin
					// out-of-range index is dropped to keep the mux in bounds
					if (pwdata < 32'(NUM_CNT)) begin
						s_nxt.sel = pwdata[IDX_W-1:0];
					end
				end
				REG_LVL: begin
					// the stored level is the reference for the next edge
					s_nxt.lvl[s_r.sel] = pwdata[3:0];
					s_nxt.cnt[s_r.sel] = step_cnt;
					s_nxt.zero[s_r.sel] = (step_cnt == '0);
					ev[IRQ_ZERO] = (step_cnt == '0) && (cur_cnt != '0);
					ev[IRQ_WRAP] = step_wrap;
				end
				REG_PRESET: s_nxt.preset = pwdata[CNT_W-1:0];
				REG_ACT: begin
					if (pwdata[0]) begin
						s_nxt.lvl[s_r.sel][LVL_EN] = 1'b1;
					end
				end
				REG_ISTS: clr = pwdata[1:0];
				REG_IMASK: s_nxt.imask = pwdata[1:0];
				default: clr = 2'h0;
			endcase
		end
		// a new event in the clearing cycle stays set
		s_nxt.ists = (s_r.ists & ~clr) | ev;
		s_nxt.irq = |(s_nxt.ists & s_nxt.imask);
		s_nxt.sel_count = s_nxt.cnt[s_nxt.sel];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.cnt <= '0;
			s_r.lvl <= {NUM_CNT{LVL_RST}};
			s_r.zero <= '1;
			s_r.sel <= '0;
			s_r.preset <= '0;
			s_r.ists <= 2'h0;
			s_r.imask <= IMASK_RST;
			s_r.irq <= 1'b0;
			s_r.prdata <= 32'h0;
			s_r.pready <= 1'b0;
			s_r.pslverr <= 1'b0;
			s_r.sel_count <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign irq = s_r.irq;
	assign zero_flags = s_r.zero;
	assign sel_count = s_r.sel_count;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic lvl_wr;
	logic up_h;
	logic dn_h;
	logic pr_h;
	logic en_h;
	assign lvl_wr = acc_wr && paddr == REG_LVL;
	assign up_h = pwdata[LVL_UP] & ~cur_lvl[LVL_UP];
	assign dn_h = pwdata[LVL_DN] & ~cur_lvl[LVL_DN];
	assign pr_h = pwdata[LVL_PR] & ~cur_lvl[LVL_PR];
	assign en_h = pwdata[LVL_EN];

	sequence count_rd_setup;
		setup && !pwrite && paddr == REG_COUNT;
	endsequence
	sequence count_rd_access;
		psel && penable && pready && !pslverr;
	endsequence
	sequence zero_rd_setup;
		setup && !pwrite && paddr == REG_ZERO;
	endsequence

	count_read_a: assert property (
		count_rd_setup ##1 count_rd_access |->
		prdata == puec_pad(cur_cnt) && $stable(cur_cnt))
		else $error("count read returned wrong value");
	up_step_a: assert property (
		lvl_wr && en_h && up_h && !dn_h && !pr_h |=>
		cur_cnt == $past(cur_cnt) + CNT_W'(1))
		else $error("up edge did not add one");
	down_step_a: assert property (
		lvl_wr && en_h && dn_h && !up_h && !pr_h |=>
		cur_cnt == $past(cur_cnt) - CNT_W'(1))
		else $error("down edge did not subtract one");
	disabled_hold_a: assert property (
		lvl_wr && !en_h && !pr_h |=> $stable(cur_cnt))
		else $error("count moved while disabled");
	preset_load_a: assert property (
		lvl_wr && pr_h |=> cur_cnt == $past(s_r.preset))
		else $error("preset edge did not load preset");
	both_edges_a: assert property (
		lvl_wr && up_h && dn_h && !pr_h |=> $stable(cur_cnt))
		else $error("opposite edges changed the count");
	level_only_a: assert property (
		lvl_wr && pwdata[3:0] == cur_lvl |=> $stable(cur_cnt))
		else $error("unchanged levels changed the count");
	zero_flag_a: assert property (
		zero_flags[s_r.sel] == (cur_cnt == '0))
		else $error("zero flag disagrees with count");
	enable_set_a: assert property (
		acc_wr && paddr == REG_ACT && pwdata[0] |=>
		s_r.lvl[s_r.sel][LVL_EN])
		else $error("activation did not raise enable");
	max_wrap_a: assert property (
		lvl_wr && en_h && up_h && !dn_h && !pr_h &&
		cur_cnt == TOP_V |=> s_r.ists[IRQ_WRAP] && cur_cnt == ~TOP_V
		##1 irq == $past(s_r.imask[IRQ_WRAP], 1) || irq)
		else $error("overflow past top value not flagged");
	irq_level_a: assert property (
		irq == |(s_r.ists & s_r.imask))
		else $error("interrupt disagrees with status and mask");
	down_wrap_a: assert property (
		lvl_wr && en_h && dn_h && !up_h && !pr_h &&
		cur_cnt == ~TOP_V |=> s_r.ists[IRQ_WRAP] && cur_cnt == TOP_V)
		else $error("wrap below bottom value not flagged");

	// bus side: one access cycle, refusals and register stores
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready stood longer than one cycle");
	unmapped_err_a: assert property (
		setup && !puec_mapped(paddr) |=> pready && pslverr)
		else $error("unmapped address not refused");
	sel_take_a: assert property (
		acc_wr && paddr == REG_SEL && pwdata < 32'(NUM_CNT) |=>
		s_r.sel == $past(pwdata[IDX_W-1:0]))
		else $error("valid index write not taken");
	sel_range_a: assert property (
		acc_wr && paddr == REG_SEL && pwdata >= 32'(NUM_CNT) |=>
		$stable(s_r.sel))
		else $error("out-of-range index changed selection");
	preset_reg_a: assert property (
		acc_wr && paddr == REG_PRESET |=>
		s_r.preset == $past(pwdata[CNT_W-1:0]))
		else $error("preset register write lost");
	imask_reg_a: assert property (
		acc_wr && paddr == REG_IMASK |=> s_r.imask == $past(pwdata[1:0]))
		else $error("mask write lost");
	ists_clear_a: assert property (
		acc_wr && paddr == REG_ISTS |=>
		(s_r.ists & $past(pwdata[1:0])) == 2'h0)
		else $error("status bit survived its clear");

	// counter side: edge reference, zero status and both outputs
	lvl_store_a: assert property (
		lvl_wr |=> cur_lvl == $past(pwdata[3:0]))
		else $error("levels not kept as edge reference");
	zero_event_a: assert property (
		lvl_wr && cur_cnt != '0 ##1 cur_cnt == '0 |->
		s_r.ists[IRQ_ZERO])
		else $error("count reaching zero not flagged");
	zero_read_a: assert property (
		zero_rd_setup ##1 count_rd_access |->
		prdata == {31'h0, zero_flags[s_r.sel]})
		else $error("zero flag read returned wrong value");
	sel_count_a: assert property (
		sel_count == cur_cnt)
		else $error("count output disagrees with selected count");
endmodule

// ==== test/puec_ctrl_model.sv ====
// Purpose: controller side that drives the counter bank over APB
// Assumes: one transfer at a time; pready is awaited with a bound
// Notes: every signal changes just after a rising edge
`timescale 1ns/1ns
module puec_ctrl_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e,
		output logic tmo);
		int i;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		tmo = (i == 16);
		psel <= 0;
		penable <= 0;
	endtask
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench of the counter bank
// Assumes: four counters keep the random walk dense
// Notes: expected counts come from a reference step function
`timescale 1ns/1ns
module tb;
	import puec_pkg::*;
	localparam int N = 4;
	logic pclk = 0;
	logic presetn = 0;
	logic psel, penable, pwrite, pready, pslverr, irq, se, tmo;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, sel_count, rv, pre;
	logic [31:0] cnt [N];
	logic [3:0] lvl [N];
	logic [N-1:0] zero_flags;
	logic [3:0] s [12] = '{4'hc, 4'h4, 4'h5, 4'h6, 4'h4, 4'h7, 4'h4,
		4'hd, 4'h0, 4'h1, 4'h3, 4'h4};
	int err_count = 0;
	int n_checks = 0;
	always #25 pclk = ~pclk;
	puec_counter_bank #(.NUM_CNT(N), .CNT_W(32)) puec_counter_bank_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.zero_flags(zero_flags), .sel_count(sel_count));
	puec_ctrl_model model_inst (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task summarize;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(string nm, logic [31:0] e, logic [31:0] v);
		n_checks++;
		if (e !== v) begin
			$display("BAD %s exp %h got %h", nm, e, v);
			err_count++;
		end
	endtask
	task bus(logic w, logic [7:0] a, logic [31:0] d);
		model_inst.xfer(w, a, d, rv, se, tmo);
		if (tmo) begin
			err_count++;
			summarize();
		end
	endtask
	function automatic logic [31:0] nxt(logic [31:0] c, logic [3:0] o,
		logic [3:0] n, logic [31:0] p);
		logic [3:0] r;
		r = n & ~o;
		if (r[3]) return p;
		if (!n[2] || (r[0] && r[1])) return c;
		return c + {31'h0, r[0]} - {31'h0, r[1]};
	endfunction
	task ev(int k, logic [3:0] v);
		logic [31:0] e;
		bus(1, REG_SEL, k);
		bus(1, REG_LVL, {28'h0, v});
		e = nxt(cnt[k], lvl[k], v, pre);
		cnt[k] = e;
		lvl[k] = v;
		@(negedge pclk);
		chk("sel_count", e, sel_count);
		chk("zero_flag", {31'h0, e == 0}, {31'h0, zero_flags[k]});
		bus(0, REG_COUNT, 0);
		chk("count_rd", e, rv);
		chk("count_kept", e, sel_count);
	endtask
	initial begin
		void'($urandom(32'he1f2));
		pre = 0;
		for (int k = 0; k < N; k++) begin
			cnt[k] = 0;
			lvl[k] = LVL_RST;
		end
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk("zero_rst", 32'hf, {28'h0, zero_flags});
		chk("irq_rst", 32'h0, {31'h0, irq});
		bus(0, REG_LVL, 0);
		chk("lvl_rst", 32'h4, rv);
		pre = 32'h5;
		bus(1, REG_PRESET, pre);
		foreach (s[i]) ev(1, s[i]);
		// small presets make zero crossings frequent
		repeat (150) begin
			if ($urandom % 8 == 0) begin
				pre = $urandom % 3;
				bus(1, REG_PRESET, pre);
			end
			ev($urandom % N, 4'($urandom));
		end
		ev(0, 4'h0);
		bus(1, REG_ACT, 1);
		lvl[0] = 4'h4;
		bus(0, REG_LVL, 0);
		chk("act_en", 32'h4, rv);
		bus(1, REG_ISTS, 3);
		pre = CNT_MAX;
		bus(1, REG_PRESET, pre);
		ev(3, 4'h4);
		ev(3, 4'hc);
		ev(3, 4'h5);
		bus(0, REG_ISTS, 0);
		chk("wrap_sts", 32'h2, rv);
		chk("irq_masked", 32'h0, {31'h0, irq});
		bus(1, REG_IMASK, 2);
		@(negedge pclk);
		chk("irq_on", 32'h1, {31'h0, irq});
		bus(1, REG_ISTS, 2);
		@(negedge pclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		bus(1, 8'h40, 0);
		chk("slverr", 32'h1, {31'h0, se});
		ev(3, 4'h6);
		bus(0, REG_ISTS, 0);
		chk("wrap_dn", 32'h2, rv);
		bus(1, REG_ISTS, 3);
		pre = 1;
		bus(1, REG_PRESET, pre);
		ev(2, 4'h4);
		ev(2, 4'hc);
		ev(2, 4'h6);
		bus(0, REG_ISTS, 0);
		chk("zero_sts", 32'h1, rv);
		bus(0, REG_ZERO, 0);
		chk("zero_rd", 32'h1, rv);
		bus(1, REG_SEL, N);
		bus(0, REG_SEL, 0);
		chk("sel_keep", 32'h2, rv);
		bus(0, REG_PRESET, 0);
		chk("preset_rd", pre, rv);
		bus(0, REG_IMASK, 0);
		chk("imask_rd", 32'h2, rv);
		summarize();
	end
endmodule
